// [include/gts_pkg.sv]
package gts_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   // The command word stands at register number 47000, so the index is kept
   // and the byte address is four times it.
   localparam int unsigned STAMP_CMD_INDEX = 47000;
   localparam logic [19:0] STAMP_CMD_ADDR = 20'(STAMP_CMD_INDEX * 4);
   localparam logic [19:0] CTRL_ADDR = 20'h00004;
   localparam logic [19:0] SLOW_DIV_ADDR = 20'h00008;
   localparam logic [19:0] PRE_ADDR = 20'h0000C;
   localparam logic [19:0] POST_ADDR = 20'h00010;
   localparam logic [19:0] MEMSIZE_ADDR = 20'h00014;
   localparam logic [19:0] STATUS_ADDR = 20'h00018;
   localparam logic [19:0] COUNT_LO_ADDR = 20'h0001C;
   localparam logic [19:0] COUNT_HI_ADDR = 20'h00020;

   // -----------------------------------------------------------------
   // Field layouts and reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] STAMP_FEATURE_MASK = 32'h000F0000;
   localparam logic [31:0] STAMP_FIRST_SLOW_SAMPLE = 32'h00010000;
   localparam logic [31:0] NO_EXTRA_STAMP = 32'h00000000;
   localparam logic [31:0] CMD_RESET = 32'h00000000;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_STAMP_ON_BIT = 1;
   localparam int CTRL_FIFO_BIT = 2;
   localparam int CTRL_CNT_CLR_BIT = 3;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_CHAN_LSB = 6;
   localparam logic [18:0] SLOW_DIV_RESET = 19'h00008;
   localparam logic [18:0] SLOW_DIV_MIN = 19'h00008;
   localparam logic [18:0] SLOW_DIV_MAX = 19'h7FFF8;
   localparam logic [31:0] PRE_RESET = 32'h00000004;
   localparam logic [31:0] POST_RESET = 32'h00000004;
   localparam logic [31:0] MEMSIZE_RESET = 32'h00001000;

   // Gate-end alignment in samples for 16-bit samples.
   localparam logic [1:0] ALIGN_ONE_CHAN = 2'h2;
   localparam logic [1:0] ALIGN_MULTI_CHAN = 2'h1;

   localparam int STAMP_W = 56;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;

   // Recording modes.
   typedef enum logic [1:0] {
      GTS_MODE_OFF = 2'h0,
      GTS_MODE_GATE = 2'h1,
      GTS_MODE_DUAL = 2'h2
   } gts_mode_t;

   typedef enum logic [3:0] {
      GTS_IDLE = 4'h1,
      GTS_WAIT = 4'h2,
      GTS_OPEN = 4'h4,
      GTS_POST = 4'h8
   } gts_state_t;

endpackage

// [hw/gts_stamp_mem.sv]
`timescale 1ns/1ns
module gts_stamp_mem (
   input wire logic clk, // Sampling clock.
   input wire logic wr_en, // Write strobe.
   input wire logic [gts_pkg::FIFO_AW-1:0] wr_addr, // Write address.
   input wire logic [gts_pkg::STAMP_W-1:0] wr_data, // Write data.
   input wire logic [gts_pkg::FIFO_AW-1:0] rd_addr, // Read address.
   output logic [gts_pkg::STAMP_W-1:0] rd_data // Registered read data.
);
   logic [gts_pkg::STAMP_W-1:0] mem [gts_pkg::FIFO_DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // gts_stamp_mem

// [hw/gts_sequencer.sv]
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
// What this block does
// - Gate length rounds up to alignment unit
// - Alignment adds up to unit minus one
// - Stamps taken at true gate edges
// - Gated mode stores start then end stamp
// - First sample is start minus pretrigger
// - Length is end-start plus align, pre, post
// - Last sample is end plus align, post
// - Standard gate ends when sample count expires
// - Memory limit mid-gate adds closing stamp
// - Dual timebase stores one stamp per trigger
// - First fast sample is stamp minus pretrigger
// - Feature bit stamps first slow sample
// - Feature mask bits reserved for features
// - Zero feature field adds no stamps
// - Feature combines with every stamp mode
// - Counter runs on fast sampling clock
// - Fast segment stored at full rate
// - Slow samples stored continuously throughout
// - Slow rate divides the single clock
// - FIFO dual mode runs until stop
// - Command word is held and readable
// - Slow divider 8 to 524280 step 8
// - Slow clock is rate over divider
// - Stamps are 56-bit sampling clock counts
module gts_sequencer (
   input wire logic clk, // Sampling clock, 20 MHz.
   input wire logic reset, // Synchronous reset, active high.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [19:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic event_pin, // Gate level or trigger pin, asynchronous.
   input wire logic stop_cmd, // Host stop, one-cycle pulse.
   output logic fast_store, // Store a fast sample this cycle.
   output logic slow_store, // Store a slow sample this cycle.
   output logic [31:0] seg_length, // Length of the last finished gate segment.
   output logic seg_done, // Pulse when seg_length updates.
   output logic [gts_pkg::STAMP_W-1:0] stamp_data, // Oldest queued stamp.
   output logic stamp_valid, // Stamp available.
   input wire logic stamp_ready // Consumer takes the stamp.
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] cmd;
      logic [31:0] ctrl;
      logic [18:0] div;
      logic [31:0] pre;
      logic [31:0] post;
      logic [31:0] memsize;
      logic [2:0] sync;
      logic evt;
      gts_pkg::gts_state_t st;
      logic [gts_pkg::STAMP_W-1:0] count;
      logic [gts_pkg::STAMP_W-1:0] start_stamp;
      logic [31:0] left;
      logic [31:0] post_cnt;
      logic [1:0] align_cnt;
      logic [18:0] slow_cnt;
      logic first_slow_due;
      logic running;
      logic [31:0] seg_len;
      logic seg_done;
      logic [gts_pkg::FIFO_AW:0] wptr;
      logic [gts_pkg::FIFO_AW:0] rptr;
      logic [31:0] rdata;
      logic [1:0] ovf;
      logic head_fresh;
      logic [31:0] seg_out;
   } gts_state_reg_t;

   gts_state_reg_t s_reg;
   gts_state_reg_t s_next;

   logic push;
   logic [gts_pkg::STAMP_W-1:0] push_val;
   logic pop;
   logic [gts_pkg::STAMP_W-1:0] mem_rd;
   logic [gts_pkg::FIFO_AW-1:0] rd_addr;

   function automatic logic [31:0] lo32(input logic [gts_pkg::STAMP_W-1:0] v);
      return v[31:0];
   endfunction

   // Alignment unit for 16-bit samples.
   function automatic logic [1:0] align_unit(input logic [1:0] chans);
      return (chans == 2'h0) ? gts_pkg::ALIGN_ONE_CHAN : gts_pkg::ALIGN_MULTI_CHAN;
   endfunction

   gts_stamp_mem u_mem (
      .clk(clk),
      .wr_en(push),
      .wr_addr(s_reg.wptr[gts_pkg::FIFO_AW-1:0]),
      .wr_data(push_val),
      .rd_addr(rd_addr),
      .rd_data(mem_rd)
   );

   // Reading ahead keeps the registered memory output aligned with the head.
   assign rd_addr = pop ? s_reg.rptr[gts_pkg::FIFO_AW-1:0] + 4'h1 :
                          s_reg.rptr[gts_pkg::FIFO_AW-1:0];

   logic fifo_empty;
   logic fifo_full;

   assign fifo_empty = (s_reg.wptr == s_reg.rptr);
   assign fifo_full = (s_reg.wptr[gts_pkg::FIFO_AW-1:0] == s_reg.rptr[gts_pkg::FIFO_AW-1:0])
                      && (s_reg.wptr[gts_pkg::FIFO_AW] != s_reg.rptr[gts_pkg::FIFO_AW]);
   assign stamp_valid = !fifo_empty && s_reg.head_fresh;
   assign pop = stamp_valid && stamp_ready;
   assign stamp_data = mem_rd;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic apb_wr;
      logic apb_rd;
      logic en;
      logic stamp_on;
      logic fifo_mode;
      gts_pkg::gts_mode_t mode;
      logic rise;
      logic fall;
      logic slow_tick;
      logic [1:0] unit;
      logic [18:0] wdiv;
      apb_wr = 1'b0;
      apb_rd = 1'b0;
      en = 1'b0;
      stamp_on = 1'b0;
      fifo_mode = 1'b0;
      mode = gts_pkg::GTS_MODE_OFF;
      rise = 1'b0;
      fall = 1'b0;
      slow_tick = 1'b0;
      unit = 2'h0;
      wdiv = 19'h0;
      s_next = s_reg;
      push = 1'b0;
      push_val = s_reg.count;
      fast_store = 1'b0;
      s_next.seg_done = 1'b0;

      apb_wr = psel && penable && pwrite;
      apb_rd = psel && !penable && !pwrite;
      en = s_reg.ctrl[gts_pkg::CTRL_ENABLE_BIT];
      stamp_on = s_reg.ctrl[gts_pkg::CTRL_STAMP_ON_BIT];
      fifo_mode = s_reg.ctrl[gts_pkg::CTRL_FIFO_BIT];
      mode = gts_pkg::gts_mode_t'(s_reg.ctrl[gts_pkg::CTRL_MODE_LSB +: 2]);
      unit = align_unit(s_reg.ctrl[gts_pkg::CTRL_CHAN_LSB +: 2]);

      // Three-stage pin synchroniser; a change counts once stages two and three agree.
      s_next.sync = {s_reg.sync[1:0], event_pin};
      if (s_reg.sync[2] == s_reg.sync[1]) begin
         s_next.evt = s_reg.sync[2];
      end
      rise = !s_reg.evt && s_next.evt && (s_reg.sync[2] == s_reg.sync[1]);
      fall = s_reg.evt && !s_next.evt && (s_reg.sync[2] == s_reg.sync[1]);

      s_next.count = s_reg.count + 56'h1;
      if (apb_wr && paddr == gts_pkg::CTRL_ADDR && pwdata[gts_pkg::CTRL_CNT_CLR_BIT]) begin
         s_next.count = '0;
      end

      // Slow timebase from the one sampling clock.
      slow_tick = s_reg.running && (s_reg.slow_cnt == 19'h0);
      if (s_reg.running) begin
         s_next.slow_cnt = slow_tick ? s_reg.div - 19'h1 : s_reg.slow_cnt - 19'h1;
      end

      // Register writes.
      if (apb_wr) begin
         case (paddr)
            gts_pkg::STAMP_CMD_ADDR: s_next.cmd = pwdata;
            gts_pkg::CTRL_ADDR: s_next.ctrl = pwdata & ~(32'h1 << gts_pkg::CTRL_CNT_CLR_BIT);
            gts_pkg::SLOW_DIV_ADDR: begin
               wdiv = pwdata[18:0] & 19'h7FFF8;
               if (wdiv < gts_pkg::SLOW_DIV_MIN) begin
                  wdiv = gts_pkg::SLOW_DIV_MIN;
               end
               s_next.div = wdiv;
            end
            gts_pkg::PRE_ADDR: s_next.pre = pwdata;
            gts_pkg::POST_ADDR: s_next.post = pwdata;
            gts_pkg::MEMSIZE_ADDR: s_next.memsize = pwdata;
            default: s_next.ovf = s_reg.ovf;
         endcase
      end

      // Sequencer.
      case (s_reg.st)
         gts_pkg::GTS_IDLE: begin
            if (en && mode != gts_pkg::GTS_MODE_OFF) begin
               s_next.st = gts_pkg::GTS_WAIT;
               s_next.running = 1'b1;
               s_next.slow_cnt = 19'h0;
               s_next.left = s_reg.memsize;
               s_next.first_slow_due =
                  (s_reg.cmd & gts_pkg::STAMP_FIRST_SLOW_SAMPLE) != gts_pkg::NO_EXTRA_STAMP;
            end
         end
         gts_pkg::GTS_WAIT: begin
            if (rise) begin
               s_next.start_stamp = s_reg.count;
               push = stamp_on;
               s_next.st = gts_pkg::GTS_OPEN;
               s_next.post_cnt = s_reg.post;
               s_next.align_cnt = 2'h0;
            end
         end
         gts_pkg::GTS_OPEN: begin
            fast_store = 1'b1;
            s_next.align_cnt = (s_reg.align_cnt == unit - 2'h1) ? 2'h0 : s_reg.align_cnt + 2'h1;
            if (mode == gts_pkg::GTS_MODE_DUAL) begin
               s_next.post_cnt = s_reg.post_cnt - 32'h1;
               if (s_reg.post_cnt <= 32'h1) begin
                  s_next.st = gts_pkg::GTS_WAIT;
               end
            end else if (fall || (s_reg.left <= 32'h1 && !fifo_mode)) begin
               push = stamp_on;
               s_next.seg_len = lo32(s_reg.count - s_reg.start_stamp) + s_reg.pre + s_reg.post;
               s_next.st = gts_pkg::GTS_POST;
            end
         end
         gts_pkg::GTS_POST: begin
            fast_store = 1'b1;
            if (s_reg.align_cnt != 2'h0) begin
               // Extends to the next boundary, at most unit minus one samples.
               s_next.align_cnt = (s_reg.align_cnt == unit - 2'h1) ? 2'h0 : s_reg.align_cnt + 2'h1;
               s_next.seg_len = s_reg.seg_len + 32'h1;
            end else begin
               s_next.post_cnt = s_reg.post_cnt - 32'h1;
               if (s_reg.post_cnt <= 32'h1) begin
                  s_next.seg_done = 1'b1;
                  s_next.st = gts_pkg::GTS_WAIT;
               end
            end
         end
         default: s_next.st = gts_pkg::GTS_IDLE;
      endcase

      if (fast_store && mode == gts_pkg::GTS_MODE_GATE && !fifo_mode) begin
         s_next.left = (s_reg.left == 32'h0) ? 32'h0 : s_reg.left - 32'h1;
         if (s_reg.left <= 32'h1) begin
            s_next.st = gts_pkg::GTS_IDLE;
            s_next.running = 1'b0;
            s_next.seg_done = 1'b1;
            s_next.ctrl[gts_pkg::CTRL_ENABLE_BIT] = 1'b0;
         end
      end

      // The output length moves only with seg_done, so no partial sum is ever shown.
      if (s_next.seg_done) begin
         s_next.seg_out = s_next.seg_len;
      end

      // First slow sample stamp waits for the next slow tick if a trigger stamp has the slot.
      if (slow_tick && s_reg.first_slow_due && !push) begin
         push = 1'b1;
         s_next.first_slow_due = 1'b0;
      end

      // Only the host stop or a disable ends a FIFO run.
      if (stop_cmd || (!en && s_reg.st != gts_pkg::GTS_IDLE)) begin
         s_next.st = gts_pkg::GTS_IDLE;
         s_next.running = 1'b0;
         s_next.first_slow_due = 1'b0;
         s_next.ctrl[gts_pkg::CTRL_ENABLE_BIT] = 1'b0;
      end

      // Stamps queue in capture order; overflow drops and counts.
      if (push && fifo_full) begin
         push = 1'b0;
         s_next.ovf = (s_reg.ovf == 2'h3) ? 2'h3 : s_reg.ovf + 2'h1;
      end
      if (push) begin
         s_next.wptr = s_reg.wptr + 5'h1;
      end
      if (pop) begin
         s_next.rptr = s_reg.rptr + 5'h1;
      end
      // The memory needs one cycle after a write into an empty queue.
      s_next.head_fresh = !fifo_empty && !pop;

      // Read data is latched in the setup cycle.
      if (apb_rd) begin
         case (paddr)
            gts_pkg::STAMP_CMD_ADDR: s_next.rdata = s_reg.cmd;
            gts_pkg::CTRL_ADDR: s_next.rdata = s_reg.ctrl;
            gts_pkg::SLOW_DIV_ADDR: s_next.rdata = {13'h0, s_reg.div};
            gts_pkg::PRE_ADDR: s_next.rdata = s_reg.pre;
            gts_pkg::POST_ADDR: s_next.rdata = s_reg.post;
            gts_pkg::MEMSIZE_ADDR: s_next.rdata = s_reg.memsize;
            gts_pkg::STATUS_ADDR: s_next.rdata = {22'h0, s_reg.ovf, s_reg.running,
                                                  fifo_empty, fifo_full, 1'b0, s_reg.st};
            gts_pkg::COUNT_LO_ADDR: s_next.rdata = lo32(s_reg.count);
            gts_pkg::COUNT_HI_ADDR: s_next.rdata = {8'h0, s_reg.count[55:32]};
            default: s_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.cmd <= gts_pkg::CMD_RESET;
         s_reg.ctrl <= gts_pkg::CTRL_RESET;
         s_reg.div <= gts_pkg::SLOW_DIV_RESET;
         s_reg.pre <= gts_pkg::PRE_RESET;
         s_reg.post <= gts_pkg::POST_RESET;
         s_reg.memsize <= gts_pkg::MEMSIZE_RESET;
         s_reg.st <= gts_pkg::GTS_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   function automatic logic mapped(input logic [19:0] a);
      return a == gts_pkg::STAMP_CMD_ADDR || (a >= gts_pkg::CTRL_ADDR &&
             a <= gts_pkg::COUNT_HI_ADDR && a[1:0] == 2'h0);
   endfunction

   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped(paddr);
   assign prdata = s_reg.rdata;
   assign slow_store = s_reg.running && s_reg.slow_cnt == 19'h0;
   assign seg_length = s_reg.seg_out;
   assign seg_done = s_reg.seg_done;

endmodule // gts_sequencer

// [tb/gts_sequencer_asserts.sv]
`timescale 1ns/1ns
module gts_sequencer_asserts (
   input wire logic clk, // Clock.
   input wire logic reset, // Reset.
   input wire logic psel, // Select.
   input wire logic penable, // Enable.
   input wire logic pwrite, // Direction.
   input wire logic [19:0] paddr, // Address.
   input wire logic [31:0] pwdata, // Write data.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Error.
   input wire logic stop_cmd, // Stop.
   input wire logic fast_store, // Fast tick.
   input wire logic slow_store, // Slow tick.
   input wire logic [31:0] seg_length, // Segment length.
   input wire logic seg_done, // Length update.
   input wire logic [gts_pkg::STAMP_W-1:0] stamp_data, // Stamp head.
   input wire logic stamp_valid, // Stamp valid.
   input wire logic stamp_ready // Stamp taken.
);
   // ----------------------------------------------------------------
   // Shadow of the command word
   // ----------------------------------------------------------------
   logic [31:0] cmd_shadow_reg;
   logic cmd_wr;
   logic cmd_rd;
   assign cmd_wr = psel && penable && pwrite && paddr == gts_pkg::STAMP_CMD_ADDR;
   assign cmd_rd = psel && penable && !pwrite && paddr == gts_pkg::STAMP_CMD_ADDR;
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_shadow_reg <= gts_pkg::CMD_RESET;
      end else if (cmd_wr) begin
         cmd_shadow_reg <= pwdata;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   bus_ready_a: assert property (pready == (psel && penable))
      else $error("pready does not follow the access phase");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside an access phase");
   err_data_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("refused read returns data");
   cmd_readback_a: assert property (cmd_rd |-> prdata == cmd_shadow_reg)
      else $error("command word read back differs");
   stamp_hold_a: assert property (stamp_valid && !stamp_ready |=> stamp_valid && $stable(stamp_data))
      else $error("offered stamp changed before it was taken");
   slow_spacing_a: assert property (slow_store |=> !slow_store [*7])
      else $error("slow ticks closer than the minimum divider");
   // The past-reset term keeps the reset clearing of the length from counting as an update.
   seg_update_a: assert property ($changed(seg_length) && !$past(reset) |-> seg_done)
      else $error("segment length changed without seg_done");
   seg_pulse_a: assert property (seg_done |=> !seg_done)
      else $error("seg_done longer than one cycle");
   stop_quiet_a: assert property (stop_cmd |-> ##2 (!slow_store && !fast_store) [*4])
      else $error("sampling continues after stop");
endmodule // gts_sequencer_asserts

// [tb/gts_far_side.sv]
`timescale 1ns/1ns
module gts_far_side (
   input wire logic clk, // Sampling clock.
   output logic event_pin, // Gate or trigger level.
   input wire logic stamp_valid, // Stamp offered.
   input wire logic [gts_pkg::STAMP_W-1:0] stamp_data, // Stamp head.
   output logic stamp_ready // Stamp taken.
);
   logic [gts_pkg::STAMP_W-1:0] q [$];
   initial begin
      event_pin = 1'h0;
      stamp_ready = 1'h0;
   end
   // Random stalls make the queue hold its head across several cycles.
   always @(posedge clk) begin
      if (stamp_valid === 1'h1 && stamp_ready === 1'h1) begin
         q.push_back(stamp_data);
      end
      stamp_ready <= ($urandom % 3) != 0;
   end
   task pulse(input int n);
      event_pin <= 1'h1;
      repeat (n) @(posedge clk);
      event_pin <= 1'h0;
      @(posedge clk);
   endtask
endmodule // gts_far_side

// [tb/gts_sequencer_tb_top.sv]
`timescale 1ns/1ns
module gts_sequencer_tb_top;
   logic clk, reset, psel, penable, pwrite, stop_cmd, pready, pslverr, event_pin;
   logic fast_store, slow_store, seg_done, stamp_valid, stamp_ready, e;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, seg_length, r, v;
   logic [31:0] seg_seen = 32'h0;
   logic [gts_pkg::STAMP_W-1:0] stamp_data;
   int error_cnt, compares, cyc, fast_cnt, slow_cnt, seg_cnt, n, f;
   logic [19:0] ra [6] = '{gts_pkg::STAMP_CMD_ADDR, gts_pkg::CTRL_ADDR, gts_pkg::SLOW_DIV_ADDR,
      gts_pkg::PRE_ADDR, gts_pkg::POST_ADDR, gts_pkg::MEMSIZE_ADDR};
   logic [31:0] rv [6] = '{gts_pkg::CMD_RESET, gts_pkg::CTRL_RESET, 32'(gts_pkg::SLOW_DIV_RESET),
      gts_pkg::PRE_RESET, gts_pkg::POST_RESET, gts_pkg::MEMSIZE_RESET};
   logic [31:0] dw [4] = '{32'h00000013, 32'h00000000, 32'hFFFFFFFF, 32'h00000010};
   logic [31:0] dr [4] = '{32'h00000010, 32'h00000008, 32'h0007FFF8, 32'h00000010};

   gts_sequencer uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_pin(event_pin), .stop_cmd(stop_cmd), .fast_store(fast_store),
      .slow_store(slow_store), .seg_length(seg_length), .seg_done(seg_done),
      .stamp_data(stamp_data), .stamp_valid(stamp_valid), .stamp_ready(stamp_ready));
   gts_far_side far (.clk(clk), .event_pin(event_pin), .stamp_valid(stamp_valid),
      .stamp_data(stamp_data), .stamp_ready(stamp_ready));

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (fast_store) fast_cnt <= fast_cnt + 1;
      if (slow_store) slow_cnt <= slow_cnt + 1;
      if (seg_done) begin
         seg_cnt <= seg_cnt + 1;
         seg_seen <= seg_length;
      end
      if (cyc >= 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [19:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic er);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] ch, input logic ff);
      return {24'h000000, ch, md, 1'h0, ff, 2'h3};
   endfunction
   task stop_run;
      stop_cmd <= 1'h1;
      @(posedge clk);
      stop_cmd <= 1'h0;
      repeat (8) @(posedge clk);
   endtask
   task wait_q(input int cnt);
      for (int i = 0; i < 400 && far.q.size() < cnt; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(far.q.size(), cnt);
   endtask
   task run_gate(input int g, input logic [1:0] ch);
      int b, s, fc, al, pre, post, len;
      logic [31:0] rd;
      logic er;
      al = (ch == 2'h0) ? 2 : 1;
      len = ((g + al - 1) / al) * al;
      pre = 4 * (1 + $urandom % 4);
      post = 4 * (1 + $urandom % 4);
      apb(1'h1, gts_pkg::PRE_ADDR, 32'(pre), rd, er);
      apb(1'h1, gts_pkg::POST_ADDR, 32'(post), rd, er);
      apb(1'h1, gts_pkg::STAMP_CMD_ADDR, gts_pkg::NO_EXTRA_STAMP, rd, er);
      b = far.q.size();
      s = seg_cnt;
      fc = fast_cnt;
      apb(1'h1, gts_pkg::CTRL_ADDR, ctl(2'h1, ch, 1'h0), rd, er);
      repeat (4) @(posedge clk);
      far.pulse(g);
      wait_q(b + 2);
      for (int i = 0; i < 100 && seg_cnt == s; i++) @(posedge clk);
      chk(far.q[b + 1] - far.q[b], g);
      chk(seg_seen, len + pre + post);
      chk(fast_cnt - fc, len + post);
      stop_run();
   endtask
   task run_dual(input logic [31:0] cmd, input int nt);
      int b, s, k;
      logic [31:0] rd, t;
      logic er;
      b = far.q.size();
      k = (cmd != 32'h0) ? 1 : 0;
      apb(1'h1, gts_pkg::STAMP_CMD_ADDR, cmd, rd, er);
      apb(1'h1, gts_pkg::CTRL_ADDR, ctl(2'h2, 2'h0, 1'h1), rd, er);
      repeat (20) @(posedge clk);
      s = slow_cnt;
      for (int i = 0; i < nt; i++) begin
         far.pulse(2);
         repeat (77) @(posedge clk);
      end
      chk(slow_cnt - s, nt * 5);
      wait_q(b + nt + k);
      for (int i = 1; i < nt + k; i++) begin
         chk(far.q[b + i] > far.q[b + i - 1], 1'h1);
         if (i > k) chk(far.q[b + i] - far.q[b + i - 1], 80);
      end
      // A counter clear while running restarts the count from zero.
      apb(1'h1, gts_pkg::CTRL_ADDR, ctl(2'h2, 2'h0, 1'h1) | (32'h1 << gts_pkg::CTRL_CNT_CLR_BIT),
         rd, er);
      apb(1'h0, gts_pkg::COUNT_LO_ADDR, 32'h0, t, er);
      chk(t, 32'h1);
      // Read data is latched at the end of setup, so two reads sit three cycles apart.
      apb(1'h0, gts_pkg::COUNT_LO_ADDR, 32'h0, t, er);
      apb(1'h0, gts_pkg::COUNT_LO_ADDR, 32'h0, rd, er);
      chk(rd - t, 3);
      apb(1'h0, gts_pkg::CTRL_ADDR, 32'h0, rd, er);
      chk(rd[0], 1'h1);
      stop_run();
      apb(1'h0, gts_pkg::CTRL_ADDR, 32'h0, rd, er);
      chk(rd[0], 1'h0);
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 20'h00000;
      pwdata = 32'h0;
      stop_cmd = 1'h0;
      void'($urandom(32'h9788));
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         apb(1'h0, ra[i], 32'h0, r, e);
         chk(r, rv[i]);
      end
      apb(1'h0, 20'h00FFC, 32'h0, r, e);
      chk({e, r}, {1'h1, 32'h0});
      apb(1'h1, 20'h00FFC, 32'hFFFFFFFF, r, e);
      chk(e, 1'h1);
      for (int i = 0; i < 4; i++) begin
         v = $urandom | (i[0] ? gts_pkg::STAMP_FIRST_SLOW_SAMPLE : gts_pkg::NO_EXTRA_STAMP);
         apb(1'h1, gts_pkg::STAMP_CMD_ADDR, v, r, e);
         apb(1'h0, gts_pkg::STAMP_CMD_ADDR, 32'h0, r, e);
         chk(r, v);
         apb(1'h1, gts_pkg::SLOW_DIV_ADDR, dw[i], r, e);
         apb(1'h0, gts_pkg::SLOW_DIV_ADDR, 32'h0, r, e);
         chk(r, dr[i]);
      end
      run_gate(7, 2'h0);
      for (int i = 0; i < 3; i++) run_gate(3 + $urandom % 12, 2'($urandom % 2));
      apb(1'h1, gts_pkg::MEMSIZE_ADDR, 32'h00000020, r, e);
      n = far.q.size();
      f = fast_cnt;
      apb(1'h1, gts_pkg::CTRL_ADDR, ctl(2'h1, 2'h0, 1'h0), r, e);
      repeat (4) @(posedge clk);
      far.pulse(100);
      wait_q(n + 2);
      chk(fast_cnt - f, 32);
      apb(1'h0, gts_pkg::CTRL_ADDR, 32'h0, r, e);
      chk(r[0], 1'h0);
      apb(1'h1, gts_pkg::MEMSIZE_ADDR, gts_pkg::MEMSIZE_RESET, r, e);
      run_dual(gts_pkg::NO_EXTRA_STAMP, 2);
      run_dual(gts_pkg::STAMP_FIRST_SLOW_SAMPLE | 32'h00000001, 3);
      end_of_test();
   end
endmodule // gts_sequencer_tb_top

bind gts_sequencer gts_sequencer_asserts sva_i (.clk(clk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .stop_cmd(stop_cmd), .fast_store(fast_store),
   .slow_store(slow_store), .seg_length(seg_length), .seg_done(seg_done),
   .stamp_data(stamp_data), .stamp_valid(stamp_valid), .stamp_ready(stamp_ready));
